// ---- alu_exec_params.svh ----
// Purpose: Named constants for the execute block and its register map
// Assumes: Included by bare name from every file except the package
// Notes:   Definitions only
`ifndef ALU_EXEC_PARAMS_SVH
`define ALU_EXEC_PARAMS_SVH

// Register byte offsets
`define OFF_CTRL        8'h00
`define OFF_OPA         8'h04
`define OFF_OPB         8'h08
`define OFF_SREG        8'h0c
`define OFF_PC          8'h10
`define OFF_ZPTR        8'h14
`define OFF_SP          8'h18
`define OFF_RETA        8'h1c
`define OFF_RESULT      8'h20
`define OFF_STATUS      8'h24

// Control word fields
`define CTRL_OP_MSB     4
`define CTRL_OP_LSB     0
`define CTRL_BIT_MSB    7
`define CTRL_BIT_LSB    5
`define CTRL_TWO_WORD   8
`define OP_COUNT        5'h1d

// Status flag positions
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_V          3
`define FLAG_S          4
`define FLAG_H          5

// Data widths and sign positions
`define BYTE_MSB        7
`define NIB_MSB         3
`define WORD_MSB        15
`define WORD_K_MSB      5
`define JUMP_K_MSB      11

// Cycle counts
`define CYC_IDLE        2'h0
`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3

// Program counter and stack steps
`define PC_STEP         16'h0001
`define PC_SKIP_ONE     16'h0002
`define PC_SKIP_TWO     16'h0003
`define STACK_STEP      16'h0002

// Bus encodings
`define HTRANS_ACTIVE   1
`define HSIZE_WORD      3'h2
`define ADDR_MSB        7
`define ADDR_LSB        0

`endif

// ---- alu_exec_pkg.sv ----
// Purpose: Types shared by the execute block
// Assumes: Operation codes follow declaration order from zero
// Notes:   Codes from OP_COUNT upward are illegal and ignored
package alu_exec_pkg;

  typedef enum logic [4:0] {
    OP_ADD,
    OP_ADD_CARRY,
    OP_WORD_PLUS_IMMEDIATE,
    OP_SUB,
    OP_DIFFERENCE_WITH_CONSTANT,
    OP_DIFFERENCE_REGS_WITH_BORROW,
    OP_DIFFERENCE_CONSTANT_WITH_BORROW,
    OP_WORD_MINUS_IMMEDIATE,
    OP_AND,
    OP_BITWISE_CONJUNCTION_CONST,
    OP_OR,
    OP_BITWISE_DISJUNCTION_CONST,
    OP_BITWISE_EXCLUSIVE_DISJUNCTION,
    OP_ONES_INVERT,
    OP_TWOS_INVERT,
    OP_MASK_BITS_HIGH,
    OP_MASK_BITS_LOW,
    OP_ZERO_MINUS_CHECK,
    OP_RELATIVE_GOTO,
    OP_POINTER_GOTO,
    OP_RELATIVE_SUBROUTINE_ENTRY,
    OP_POINTER_SUBROUTINE_ENTRY,
    OP_EQUAL_THEN_SKIP,
    OP_REGISTER_COMPARE,
    OP_COMPARE_WITH_BORROW,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_LOW,
    OP_SKIP_REG_BIT_HIGH,
    OP_SKIP_IO_BIT_LOW
  } op_e;

  typedef struct packed {
    logic        dataPhase;
    logic        dpWrite;
    logic        dpWordSize;
    logic [7:0]  dpAddr;
    logic        rdWait;
    logic [31:0] rdData;
    op_e         lastOp;
    logic [2:0]  bitSel;
    logic        twoWord;
    logic [15:0] opA;
    logic [15:0] opB;
    logic [7:0]  sreg;
    logic [15:0] pc;
    logic [15:0] zPtr;
    logic [15:0] sp;
    logic [15:0] retAddr;
    logic [15:0] result;
    logic [1:0]  busyCnt;
    logic [1:0]  lastCycles;
    logic        skipped;
  } state_s;

endpackage

// ---- alu_byte_arith.sv ----
// Purpose: Byte adder and subtractor with status flag terms
// Assumes: Borrow enters as carryIn when subtract is high
// Notes:   Purely combinational
`include "alu_exec_params.svh"

module alu_byte_arith (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       carryIn,
  input  wire logic       subtract,
  output logic      [7:0] sum,
  output logic            halfCarry,
  output logic            overflow,
  output logic            carryOut,
  output logic            negative,
  output logic            zero
);

  logic [7:0] cinByte;
  logic       a7, b7, r7, a3, b3, r3;

  assign cinByte = {7'h00, carryIn};
  assign sum = subtract ? (a - b - cinByte) : (a + b + cinByte);
  assign a7 = a[`BYTE_MSB];
  assign b7 = b[`BYTE_MSB];
  assign r7 = sum[`BYTE_MSB];
  assign a3 = a[`NIB_MSB];
  assign b3 = b[`NIB_MSB];
  assign r3 = sum[`NIB_MSB];

  // Borrow terms mirror the carry terms with the minuend and the result inverted
  assign halfCarry = subtract ? ((~a3 & b3) | (b3 & r3) | (r3 & ~a3))
                              : ((a3 & b3) | (b3 & ~r3) | (~r3 & a3));
  assign carryOut  = subtract ? ((~a7 & b7) | (b7 & r7) | (r7 & ~a7))
                              : ((a7 & b7) | (b7 & ~r7) | (~r7 & a7));
  assign overflow  = subtract ? ((a7 & ~b7 & ~r7) | (~a7 & b7 & r7))
                              : ((a7 & b7 & ~r7) | (~a7 & ~b7 & r7));
  assign negative  = r7;
  assign zero      = (sum == 8'h00);

endmodule // alu_byte_arith

// ---- alu_branch_execute.sv ----
// Purpose: Executes arithmetic, logic, jump, call, compare and skip ops
// Assumes: Single AHB-Lite slave, hready is this slave's hreadyout
// Notes:   A control write while idle starts one operation on the held operands
//
// Contract
// (RL1) Register add, with carry, five flags, one cycle
// (RL2) Word plus immediate, Z C N V S, two cycles
// (RL3) Word minus immediate, Z C N V S, two cycles
// (RL4) Subtract register or constant, five flags, one cycle
// (RL5) Subtract with borrow also removes carry
// (RL6) AND OR XOR store result, Z N V
// (RL7) Two's and one's complement with their flags
// (RL8) Set bits ORs mask, Z N V, one cycle
// (RL9) Clear bits ANDs inverted mask, one cycle
// (RL10) Zero-minus check leaves value, sets Z N V
// (RL11) Relative or pointer jump, two cycles, no flags
// (RL12) Calls save return address, three cycles
// (RL13) Equal-then-skip: one, two or three cycles
// (RL14) Compares set five flags, no writeback
// (RL15) Skip when register bit is clear
// (RL16) Skip when register bit is set, no flags
// (RL17) Skip when I/O bit is clear, no flags
// (RL18) Sign equals negative XOR overflow; S is only updated by the word plus and minus immediate ops
`include "alu_exec_params.svh"

module alu_branch_execute (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [31:0]         hrdata,
  input  wire logic [7:0]          ioValue,
  output logic                     busy,
  output alu_exec_pkg::op_e        activeOp
);

  import alu_exec_pkg::*;

  state_s      st, next_st;
  logic        start, newTwoWord, isSubOp, useCarry;
  op_e         newOp;
  logic [2:0]  newBit;
  logic [7:0]  arithA, arithB;
  logic [7:0]  arithSum;
  logic        arithH, arithV, arithC, arithN, arithZ;
  logic [15:0] wordK, wordSum, wordDiff, pcRel;
  logic [31:0] readMux;

  assign newOp      = op_e'(hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
  assign newBit     = hwdata[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
  assign newTwoWord = hwdata[`CTRL_TWO_WORD];
  assign start = st.dataPhase && st.dpWrite && st.dpWordSize
              && (st.dpAddr == `OFF_CTRL) && (st.busyCnt == `CYC_IDLE)
              && (hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] < `OP_COUNT);

  assign isSubOp = newOp inside {OP_SUB, OP_DIFFERENCE_WITH_CONSTANT,
    OP_DIFFERENCE_REGS_WITH_BORROW, OP_DIFFERENCE_CONSTANT_WITH_BORROW,
    OP_TWOS_INVERT, OP_REGISTER_COMPARE, OP_COMPARE_WITH_BORROW,
    OP_COMPARE_IMMEDIATE};
  assign useCarry = newOp inside {OP_ADD_CARRY,
    OP_DIFFERENCE_REGS_WITH_BORROW, OP_DIFFERENCE_CONSTANT_WITH_BORROW,
    OP_COMPARE_WITH_BORROW};
  // Two's complement runs as zero minus the register
  assign arithA = (newOp == OP_TWOS_INVERT) ? 8'h00 : st.opA[7:0];
  assign arithB = (newOp == OP_TWOS_INVERT) ? st.opA[7:0] : st.opB[7:0];
  alu_byte_arith u_arith (
    .a         (arithA),
    .b         (arithB),
    .carryIn   (useCarry & st.sreg[`FLAG_C]),
    .subtract  (isSubOp),
    .sum       (arithSum),
    .halfCarry (arithH),
    .overflow  (arithV),
    .carryOut  (arithC),
    .negative  (arithN),
    .zero      (arithZ)
  );

  assign wordK    = {10'h000, st.opB[`WORD_K_MSB:0]};
  assign wordSum  = st.opA + wordK;
  assign wordDiff = st.opA - wordK;
  assign pcRel    = st.pc + {{4{st.opB[`JUMP_K_MSB]}},
                             st.opB[`JUMP_K_MSB:0]} + `PC_STEP;

  always_comb begin
    unique case (st.dpAddr)
      `OFF_CTRL:   readMux = {23'h000000, st.twoWord, st.bitSel, st.lastOp};
      `OFF_OPA:    readMux = {16'h0000, st.opA};
      `OFF_OPB:    readMux = {16'h0000, st.opB};
      `OFF_SREG:   readMux = {24'h000000, st.sreg};
      `OFF_PC:     readMux = {16'h0000, st.pc};
      `OFF_ZPTR:   readMux = {16'h0000, st.zPtr};
      `OFF_SP:     readMux = {16'h0000, st.sp};
      `OFF_RETA:   readMux = {16'h0000, st.retAddr};
      `OFF_RESULT: readMux = {16'h0000, st.result};
      `OFF_STATUS: readMux = {28'h0000000, st.lastCycles, st.skipped,
                              busy};
      default:     readMux = 32'h00000000;
    endcase
  end

  always_comb begin
    logic [7:0]  lres;
    logic        wV;
    logic        wC;
    logic [15:0] wRes;
    logic        skipCond;
    logic [1:0]  cyc;
    lres     = 8'h00;
    wV       = 1'b0;
    wC       = 1'b0;
    wRes     = 16'h0000;
    skipCond = 1'b0;
    cyc      = `CYC_ONE;
    next_st  = st;
    if (st.busyCnt != `CYC_IDLE) begin
      next_st.busyCnt = st.busyCnt - `CYC_ONE;
    end
    // Reads take one wait state so a preceding write is seen
    if (st.rdWait) begin
      next_st.rdWait = 1'b0;
      next_st.rdData = readMux;
    end
    if (hready) begin
      next_st.dataPhase  = hsel && htrans[`HTRANS_ACTIVE];
      next_st.dpWrite    = hwrite;
      next_st.dpWordSize = (hsize == `HSIZE_WORD);
      next_st.dpAddr     = haddr[`ADDR_MSB:`ADDR_LSB];
      next_st.rdWait     = hsel && htrans[`HTRANS_ACTIVE] && !hwrite;
    end
    if (st.dataPhase && st.dpWrite && st.dpWordSize) begin
      unique case (st.dpAddr)
        `OFF_OPA:  next_st.opA  = hwdata[15:0];
        `OFF_OPB:  next_st.opB  = hwdata[15:0];
        `OFF_SREG: next_st.sreg = hwdata[7:0];
        `OFF_PC:   next_st.pc   = hwdata[15:0];
        `OFF_ZPTR: next_st.zPtr = hwdata[15:0];
        `OFF_SP:   next_st.sp   = hwdata[15:0];
        default: ;
      endcase
    end
    if (start) begin
      next_st.lastOp  = newOp;
      next_st.bitSel  = newBit;
      next_st.twoWord = newTwoWord;
      next_st.skipped = 1'b0;
      next_st.pc      = st.pc + `PC_STEP;
      unique case (newOp)
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_DIFFERENCE_WITH_CONSTANT,
        OP_DIFFERENCE_REGS_WITH_BORROW, OP_DIFFERENCE_CONSTANT_WITH_BORROW,
        OP_TWOS_INVERT, OP_REGISTER_COMPARE, OP_COMPARE_WITH_BORROW,
        OP_COMPARE_IMMEDIATE: begin
          next_st.sreg[`FLAG_H] = arithH; // RL1 RL4 RL5 RL7 RL14
          next_st.sreg[`FLAG_V] = arithV;
          next_st.sreg[`FLAG_C] = arithC;
          next_st.sreg[`FLAG_N] = arithN;
          next_st.sreg[`FLAG_Z] = arithZ;
          next_st.result = {8'h00, arithSum};
          if (!(newOp inside {OP_REGISTER_COMPARE, OP_COMPARE_WITH_BORROW,
                              OP_COMPARE_IMMEDIATE})) begin
            next_st.opA[7:0] = arithSum; // RL1 RL4 RL5 RL7
          end
        end
        OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
          if (newOp == OP_WORD_PLUS_IMMEDIATE) begin
            wRes = wordSum; // RL2
            wV = ~st.opA[`WORD_MSB] & wordSum[`WORD_MSB];
            wC = ~wordSum[`WORD_MSB] & st.opA[`WORD_MSB];
          end else begin
            wRes = wordDiff; // RL3
            wV = st.opA[`WORD_MSB] & ~wordDiff[`WORD_MSB];
            wC = wordDiff[`WORD_MSB] & ~st.opA[`WORD_MSB];
          end
          next_st.opA    = wRes;
          next_st.result = wRes;
          next_st.sreg[`FLAG_V] = wV;
          next_st.sreg[`FLAG_C] = wC;
          next_st.sreg[`FLAG_N] = wRes[`WORD_MSB];
          next_st.sreg[`FLAG_Z] = (wRes == 16'h0000);
          next_st.sreg[`FLAG_S] = wRes[`WORD_MSB] ^ wV; // RL18
          cyc = `CYC_TWO; // RL2 RL3
        end
        OP_AND, OP_BITWISE_CONJUNCTION_CONST, OP_OR,
        OP_BITWISE_DISJUNCTION_CONST, OP_BITWISE_EXCLUSIVE_DISJUNCTION,
        OP_ONES_INVERT, OP_MASK_BITS_HIGH, OP_MASK_BITS_LOW,
        OP_ZERO_MINUS_CHECK: begin
          unique case (newOp)
            OP_AND, OP_BITWISE_CONJUNCTION_CONST:
              lres = st.opA[7:0] & st.opB[7:0]; // RL6
            OP_OR, OP_BITWISE_DISJUNCTION_CONST, OP_MASK_BITS_HIGH:
              lres = st.opA[7:0] | st.opB[7:0]; // RL6 RL8
            OP_BITWISE_EXCLUSIVE_DISJUNCTION:
              lres = st.opA[7:0] ^ st.opB[7:0]; // RL6
            OP_ONES_INVERT:
              lres = 8'hff - st.opA[7:0]; // RL7
            OP_MASK_BITS_LOW:
              lres = st.opA[7:0] & (8'hff - st.opB[7:0]); // RL9
            default:
              lres = st.opA[7:0] & st.opA[7:0]; // RL10
          endcase
          next_st.opA[7:0] = lres;
          next_st.result   = {8'h00, lres};
          next_st.sreg[`FLAG_V] = 1'b0; // RL6 RL8 RL9 RL10
          next_st.sreg[`FLAG_N] = lres[`BYTE_MSB];
          next_st.sreg[`FLAG_Z] = (lres == 8'h00);
          if (newOp == OP_ONES_INVERT) begin
            next_st.sreg[`FLAG_C] = 1'b1; // RL7
          end
        end
        OP_RELATIVE_GOTO, OP_POINTER_GOTO: begin
          next_st.pc = (newOp == OP_RELATIVE_GOTO) ? pcRel : st.zPtr; // RL11
          cyc = `CYC_TWO; // RL11
        end
        OP_RELATIVE_SUBROUTINE_ENTRY, OP_POINTER_SUBROUTINE_ENTRY: begin
          next_st.retAddr = st.pc + `PC_STEP; // RL12
          next_st.sp      = st.sp - `STACK_STEP;
          next_st.pc = (newOp == OP_RELATIVE_SUBROUTINE_ENTRY)
                     ? pcRel : st.zPtr; // RL12
          cyc = `CYC_THREE; // RL12
        end
        default: begin
          unique case (newOp)
            OP_EQUAL_THEN_SKIP:
              skipCond = (st.opA[7:0] == st.opB[7:0]); // RL13
            OP_SKIP_REG_BIT_LOW:
              skipCond = !st.opA[newBit]; // RL15
            OP_SKIP_REG_BIT_HIGH:
              skipCond = st.opA[newBit]; // RL16
            default:
              skipCond = !ioValue[newBit]; // RL17
          endcase
          if (skipCond) begin
            next_st.pc = st.pc + (newTwoWord ? `PC_SKIP_TWO
                                             : `PC_SKIP_ONE);
            cyc = newTwoWord ? `CYC_THREE : `CYC_TWO; // RL13 RL15 RL16
            next_st.skipped = 1'b1;
          end
        end
      endcase
      next_st.busyCnt    = cyc;
      next_st.lastCycles = cyc;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = !st.rdWait;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdData;
  assign busy      = (st.busyCnt != `CYC_IDLE);
  assign activeOp  = st.lastOp;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_busy1; busy ##1 !busy; endsequence
  sequence s_busy2; busy [*2] ##1 !busy; endsequence
  sequence s_busy3; busy [*3] ##1 !busy; endsequence

  property p_add_one;
    start && newOp inside {OP_ADD, OP_ADD_CARRY} |=>
      (st.opA[7:0] == $past(arithSum)) && st.sreg[`FLAG_H] == $past(arithH)
      ##0 s_busy1;
  endproperty
  a_add_one: assert property (p_add_one) else $error("add wrong"); // RL1
  property p_word_plus;
    start && newOp == OP_WORD_PLUS_IMMEDIATE |=>
      (st.opA == $past(wordSum)) ##0 s_busy2;
  endproperty
  a_word_plus: assert property (p_word_plus) else $error("word plus"); // RL2
  property p_word_minus;
    start && newOp == OP_WORD_MINUS_IMMEDIATE |=>
      (st.opA == $past(wordDiff)) ##0 s_busy2;
  endproperty
  a_word_minus: assert property (p_word_minus) else $error("word sub"); // RL3
  property p_sub_one;
    start && newOp inside {OP_SUB, OP_DIFFERENCE_WITH_CONSTANT} |=>
      (st.opA[7:0] == $past(st.opA[7:0]) - $past(st.opB[7:0])) ##0 s_busy1;
  endproperty
  a_sub_one: assert property (p_sub_one) else $error("subtract"); // RL4
  property p_sub_borrow;
    start && newOp == OP_DIFFERENCE_REGS_WITH_BORROW |=>
      st.opA[7:0] == ($past(st.opA[7:0]) - $past(st.opB[7:0])
                      - {7'h00, $past(st.sreg[`FLAG_C])});
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow"); // RL5
  property p_logic_flags;
    start && newOp inside {OP_AND, OP_OR, OP_BITWISE_EXCLUSIVE_DISJUNCTION,
      OP_MASK_BITS_HIGH} |=> !st.sreg[`FLAG_V]
      && st.sreg[`FLAG_Z] == (st.opA[7:0] == 8'h00) ##0 s_busy1;
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic"); // RL6
  property p_ones_invert;
    start && newOp == OP_ONES_INVERT |=>
      st.opA[7:0] == ~$past(st.opA[7:0]) && st.sreg[`FLAG_C];
  endproperty
  a_ones_invert: assert property (p_ones_invert) else $error("invert"); // RL7
  property p_mask_low;
    start && newOp == OP_MASK_BITS_LOW |=>
      st.opA[7:0] == ($past(st.opA[7:0]) & ~$past(st.opB[7:0]));
  endproperty
  a_mask_low: assert property (p_mask_low) else $error("clear bits"); // RL9
  property p_zero_check;
    start && newOp == OP_ZERO_MINUS_CHECK |=> $stable(st.opA)
      && st.sreg[`FLAG_N] == st.opA[`BYTE_MSB];
  endproperty
  a_zero_check: assert property (p_zero_check) else $error("test"); // RL10
  property p_rel_goto;
    start && newOp == OP_RELATIVE_GOTO |=>
      st.pc == $past(pcRel) && $stable(st.sreg) ##0 s_busy2;
  endproperty
  a_rel_goto: assert property (p_rel_goto) else $error("jump"); // RL11
  property p_call;
    start && newOp inside {OP_RELATIVE_SUBROUTINE_ENTRY,
      OP_POINTER_SUBROUTINE_ENTRY} |=>
      st.retAddr == $past(st.pc) + `PC_STEP ##0 s_busy3;
  endproperty
  a_call: assert property (p_call) else $error("call wrong"); // RL12
  property p_equal_skip;
    start && newOp == OP_EQUAL_THEN_SKIP && !newTwoWord
      && st.opA[7:0] == st.opB[7:0] |=>
      st.pc == $past(st.pc) + `PC_SKIP_ONE ##0 s_busy2;
  endproperty
  a_equal_skip: assert property (p_equal_skip) else $error("skip eq"); // RL13
  property p_compare;
    start && newOp inside {OP_REGISTER_COMPARE, OP_COMPARE_IMMEDIATE} |=>
      $stable(st.opA) && st.sreg[`FLAG_C] == $past(arithC);
  endproperty
  a_compare: assert property (p_compare) else $error("compare"); // RL14
  property p_bit_low_noskip;
    start && newOp == OP_SKIP_REG_BIT_LOW && st.opA[newBit] |=>
      st.pc == $past(st.pc) + `PC_STEP ##0 s_busy1;
  endproperty
  a_bit_low_noskip: assert property (p_bit_low_noskip) // RL15
    else $error("bit-clear skip taken wrongly");
  property p_bit_high_skip;
    start && newOp == OP_SKIP_REG_BIT_HIGH && st.opA[newBit] && newTwoWord
      |=> $stable(st.sreg) && st.pc == $past(st.pc) + `PC_SKIP_TWO
      ##0 s_busy3;
  endproperty
  a_bit_high_skip: assert property (p_bit_high_skip) // RL16
    else $error("bit-set skip wrong");
  property p_io_skip;
    start && newOp == OP_SKIP_IO_BIT_LOW && !ioValue[newBit] |=>
      st.skipped && $stable(st.sreg);
  endproperty
  a_io_skip: assert property (p_io_skip) else $error("io skip"); // RL17
  property p_sign;
    start && newOp inside {OP_WORD_PLUS_IMMEDIATE,
      OP_WORD_MINUS_IMMEDIATE} |=>
      st.sreg[`FLAG_S] == (st.sreg[`FLAG_N] ^ st.sreg[`FLAG_V]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag"); // RL18
endmodule // alu_branch_execute

// ---- tb.sv ----
// Purpose: Self-checking bench for the execute block
// Assumes: One AHB-Lite master, hready tied to hreadyout
// Notes:   Random operands from a fixed seed, model in the bench
`include "alu_exec_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alu_exec_pkg::*;

  logic        mclk = 0;
  logic        reset = 1;
  logic        hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 0;
  logic [2:0]  hsize = `HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic [7:0]  ioValue = '0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        busy;
  op_e         activeOp;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          seed = 18996;

  always #12.5 mclk = ~mclk;

  alu_branch_execute i_alu_branch_execute (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ioValue(ioValue), .busy(busy),
    .activeOp(activeOp)
  );

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait for hready sampled high
  task automatic waitRdy();
    int t;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (t >= 50) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    waitRdy();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q & m, e & m);
  endtask

  // Byte add or subtract flags from integer sums, S and bits 6,7 kept
  function automatic logic [7:0] fl(input logic [7:0] x, y, r,
                                    input logic sb, c,
                                    input logic [7:0] s0);
    logic [7:0] t;
    int         xi, yi, ci;
    t = s0;
    xi = x;
    yi = y;
    ci = c;
    if (sb) begin
      t[5] = (xi % 16) < (yi % 16) + ci;
      t[0] = xi < yi + ci;
    end else begin
      t[5] = (xi % 16) + (yi % 16) + ci > 15;
      t[0] = xi + yi + ci > 255;
    end
    t[3] = (x[7] == (y[7] ^ sb)) && (r[7] != x[7]);
    t[1] = (r == 8'h0);
    t[2] = r[7];
    return t;
  endfunction

  initial begin
    logic [15:0] a, b, pc, z, sp, wa, np, rt, nsp, w, k, res;
    logic [7:0]  s, ns, r, io;
    logic [31:0] m, eSt;
    logic [2:0]  bs;
    logic        tw, sk, c;
    int          i, op, n, cyc, eOp;
    rt = 0;
    res = 0;
    eSt = 0;
    eOp = 0;
    repeat (5) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    for (i = 0; i <= 40; i += 4) rdc("reset", i[7:0], '1, 32'h0);
    // Sub-word writes are ignored
    hsize <= 3'h0;
    wr(`OFF_OPA, 32'h5a);
    hsize <= `HSIZE_WORD;
    rdc("subword", `OFF_OPA, '1, 32'h0);
    for (i = 0; i < 96; i++) begin
      op = i % 32;
      a = 16'($random(seed));
      b = 16'($random(seed));
      s = 8'($random(seed));
      pc = 16'($random(seed));
      z = 16'($random(seed));
      sp = 16'($random(seed));
      io = 8'($random(seed));
      bs = 3'($random(seed));
      tw = 1'($random(seed));
      // Steer operands so the two-word bit-set and I/O skips, a bit-clear no-skip and the one-word equal skip run
      if (i >= 64) begin
        b[7:0] = a[7:0];
        tw = 1'b0;
      end else if (i >= 32) begin
        tw = 1'b1;
        a[bs] = 1'b1;
        io[bs] = 1'b0;
      end
      ioValue <= io;
      wr(`OFF_OPA, {16'h0, a});
      wr(`OFF_OPB, {16'h0, b});
      wr(`OFF_SREG, {24'h0, s});
      wr(`OFF_PC, {16'h0, pc});
      wr(`OFF_ZPTR, {16'h0, z});
      wr(`OFF_SP, {16'h0, sp});
      wa = a;
      m = 32'hffff;
      ns = s;
      np = pc + 16'h1;
      nsp = sp;
      sk = 0;
      cyc = 1;
      k = {{4{b[11]}}, b[11:0]};
      case (op)
        0, 1, 3, 4, 5, 6, 23, 24, 25: begin
          c = (op == 1 || op == 5 || op == 6 || op == 24) ? s[0] : 1'b0;
          r = (op < 3) ? a[7:0] + b[7:0] + c : a[7:0] - b[7:0] - c;
          ns = fl(a[7:0], b[7:0], r, op >= 3, c, s);
          res = {8'h0, r};
          if (op < 23) begin
            wa[7:0] = r;
            m = 32'hff;
          end
        end
        14: begin
          r = 8'h0 - a[7:0];
          ns = fl(8'h0, a[7:0], r, 1'b1, 1'b0, s);
          res = {8'h0, r};
          wa[7:0] = r;
          m = 32'hff;
        end
        2, 7: begin
          w = (op == 2) ? a + b[5:0] : a - b[5:0];
          ns[3] = (op == 2) ? ~a[15] & w[15] : a[15] & ~w[15];
          ns[0] = (op == 2) ? a[15] & ~w[15] : w[15] & ~a[15];
          ns[1] = (w == 16'h0);
          ns[2] = w[15];
          ns[4] = w[15] ^ ns[3];
          wa = w;
          res = w;
          cyc = 2;
        end
        18, 19, 20, 21: begin
          np = (op % 2 == 0) ? pc + k + 16'h1 : z;
          cyc = (op < 20) ? 2 : 3;
          if (op > 19) begin
            rt = pc + 16'h1;
            nsp = sp - `STACK_STEP;
          end
        end
        22, 26, 27, 28: begin
          case (op)
            22: sk = (a[7:0] == b[7:0]);
            26: sk = ~a[bs];
            27: sk = a[bs];
            default: sk = ~io[bs];
          endcase
          if (sk) begin
            np = pc + 16'h2 + tw;
            cyc = 2 + tw;
          end
        end
        29, 30, 31: begin
          np = pc;
          cyc = 0;
        end
        default: begin
          case (op)
            8, 9: r = a[7:0] & b[7:0];
            12: r = a[7:0] ^ b[7:0];
            13: r = ~a[7:0];
            16: r = a[7:0] & ~b[7:0];
            17: r = a[7:0];
            default: r = a[7:0] | b[7:0];
          endcase
          ns[1] = (r == 8'h0);
          ns[2] = r[7];
          ns[3] = 0;
          if (op == 13) ns[0] = 1;
          res = {8'h0, r};
          wa[7:0] = r;
          m = 32'hff;
        end
      endcase
      if (op < 29) begin
        eSt = {28'h0, cyc[1:0], sk, 1'b0};
        eOp = op;
      end
      wr(`OFF_CTRL, {23'h0, tw, bs, op[4:0]});
      #1;
      n = 0;
      while (busy === 1'b1 && n < 8) begin
        @(posedge mclk);
        #1;
        n++;
      end
      @(posedge mclk);
      chk("cycles", n, cyc);
      chk("activeOp", activeOp, eOp);
      rdc("opa", `OFF_OPA, m, wa);
      rdc("result", `OFF_RESULT, 32'hffff, res);
      rdc("sreg", `OFF_SREG, 32'hff, ns);
      rdc("pc", `OFF_PC, 32'hffff, np);
      rdc("sp", `OFF_SP, 32'hffff, nsp);
      rdc("reta", `OFF_RETA, 32'hffff, rt);
      rdc("status", `OFF_STATUS, 32'hf, eSt);
    end
    summarize();
  end
endmodule // tb
